// ---- bench/isr_host_model.sv ----
// host model: issues status commands and collects answers
`timescale 1ns/100ps
module isr_host_model
  import isr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  output isr_req_t         req
);
  initial req = '{valid: 1'b0, cmd: ISR_NOP, sel: ISR_SEL_ENA, data: 16'h0000};
  // one command: strobe over one edge, then a bounded wait for the answer
  // full-range mask values
  task automatic xfer(input isr_cmd_t c, input isr_sel_t s, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    int i;
    @(negedge clk);
    req = '{valid: 1'b1, cmd: c, sel: s, data: d};
    @(negedge clk);
    // released data shows a changed pattern so stale values cannot pass
    req = '{valid: 1'b0, cmd: ISR_NOP, sel: s, data: ~d};
    ok = 1'b0;
    q = 16'h0000;
    for (i = 0; i < 4 && !ok; i++) begin
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        q = rsp_data;
      end else
        @(negedge clk);
    end
  endtask
endmodule

// ---- bench/isr_status_asserts.sv ----
// checker: port-level assertions for the status block
`timescale 1ns/100ps
module isr_status_asserts
  import isr_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  input wire isr_req_t    req,
  input wire isr_evq_t    evq,
  input wire isr_opcond_t opcond,
  input wire logic [NCH-1:0] chan_summary,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic        std_event_summary,
  input wire logic        oper_summary,
  input wire logic [7:0]  esr_view
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // host read of the event status register with nothing posted
  sequence s_esr_rd;
    ce && req.valid && req.cmd == ISR_ESR_RD && evq == '0;
  endsequence
  // answers, postings and read side effects
  property p_rsp; ce |=> rsp_valid == $past(req.valid); endproperty
  a_rsp: assert property (p_rsp) else $error("response strobe wrong");
  property p_pon; ce && evq.power_applied |=> esr_view[ESB_POWER]; endproperty
  a_pon: assert property (p_pon) else $error("power bit not set");
  property p_cmdf; ce && evq.cmd_fault |=> esr_view[ESB_CMD_FAULT]; endproperty
  a_cmdf: assert property (p_cmdf) else $error("command fault bit not set");
  property p_unused; (esr_view & ~ESB_USED_MASK) == 8'h00; endproperty
  a_unused: assert property (p_unused) else $error("unused event bit set");
  property p_clr; s_esr_rd |=> esr_view == 8'h00 && rsp_data == {8'h00, $past(esr_view)}; endproperty
  a_clr: assert property (p_clr) else $error("event status read wrong");
  property p_hold; ce && !(req.valid && req.cmd == ISR_ESR_RD) |=> (esr_view & $past(esr_view)) == $past(esr_view);
  endproperty
  a_hold: assert property (p_hold) else $error("event bit lost without read");
  property p_sum; esr_view == 8'h00 |-> !std_event_summary; endproperty
  a_sum: assert property (p_sum) else $error("summary without event");
  property p_opbits; ce && req.valid && req.cmd inside {ISR_OP_EVT, ISR_OP_COND} |=> (rsp_data & ~OPB_USED_MASK) == 16'h0000;
  endproperty
  a_opbits: assert property (p_opbits) else $error("unused operation bit set");
  property p_chbits; ce && req.valid && req.cmd inside {ISR_CH_EVT, ISR_CH_COND} |=> (rsp_data & ~CHS_USED_MASK) == 16'h0000;
  endproperty
  a_chbits: assert property (p_chbits) else $error("unused channel bit set");
endmodule

bind isr_status isr_status_asserts #(.NCH(NCH)) chk_u (.clk(clk), .resetn(resetn), .ce(ce), .req(req), .evq(evq),
  .opcond(opcond), .chan_summary(chan_summary), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .std_event_summary(std_event_summary), .oper_summary(oper_summary), .esr_view(esr_view));

// ---- bench/test_isr_status.sv ----
// testbench: status block driven by the host model
`timescale 1ns/100ps
module test_isr_status;
  import isr_pkg::*;
  logic        clk = 1'b0;
  logic        resetn, ce, rsp_valid, std_event_summary, oper_summary;
  isr_req_t    req;
  isr_evq_t    evq;
  isr_opcond_t opcond;
  logic [3:0]  chan_summary;
  logic [15:0] rsp_data;
  logic [7:0]  esr_view;
  int          n_mismatch = 0;
  int          comparisons = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  isr_status #(.NCH(4)) dut_u (.clk(clk), .resetn(resetn), .ce(ce), .req(req), .evq(evq), .opcond(opcond),
    .chan_summary(chan_summary), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .std_event_summary(std_event_summary), .oper_summary(oper_summary), .esr_view(esr_view));
  isr_host_model hst_u (.clk(clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .req(req));
  // verdict and end of run
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(string nm, logic e, logic g);
    chk16(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  // one command and a check of its answer; a missing answer ends the run
  task automatic op(isr_cmd_t c, logic [15:0] d, logic [15:0] e, string nm, isr_sel_t s = ISR_SEL_ENA);
    logic [15:0] q;
    logic        ok;
    hst_u.xfer(c, s, d, q, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %s expected answer seen none", nm);
      conclude();
    end else
      chk16(nm, e, q);
  endtask
  task automatic idle(int n);
    repeat (n) @(negedge clk);
  endtask
  // event status postings, enable summary and read-clear
  task automatic t_esr;
    int i;
    op(ISR_ESE_WR, 16'h0020, 16'h0000, "ese write");
    op(ISR_ESE_RD, 16'h0000, 16'h0020, "ese read");
    evq.cmd_fault = 1'b1;
    idle(1);
    evq = '0;
    idle(1);
    chk1("event summary", 1'b1, std_event_summary);
    op(ISR_ESR_RD, 16'h0000, 16'h0020, "esr fault");
    chk1("event summary", 1'b0, std_event_summary);
    for (i = 0; i < 6; i++) begin
      evq = isr_evq_t'(6'h01 << i);
      idle(1);
    end
    evq = '0;
    idle(1);
    chk16("esr view", 16'h00BD, {8'h00, esr_view});
    op(ISR_ESR_RD, 16'h0000, 16'h00BD, "esr all");
    op(ISR_ESR_RD, 16'h0000, 16'h0000, "esr cleared");
  endtask
  // operation register conditions, events, masks and summary
  task automatic t_oper;
    opcond = '1;
    idle(3);
    op(ISR_OP_COND, 16'h0000, 16'h1720, "oper cond");
    op(ISR_OP_COND, 16'h0000, 16'h1720, "oper cond again");
    op(ISR_OP_EVT, 16'h0000, 16'h1720, "oper event");
    op(ISR_OP_EVT, 16'h0000, 16'h0000, "oper event cleared");
    op(ISR_OP_ENA_WR, 16'hFFFF, 16'h0000, "oper ena write");
    op(ISR_OP_ENA_RD, 16'h0000, 16'hFFFF, "oper ena read");
    op(ISR_OP_PTR_WR, 16'h0000, 16'h0000, "oper ptr write");
    op(ISR_OP_NTR_WR, 16'h0200, 16'h0000, "oper ntr write");
    op(ISR_OP_PTR_RD, 16'h0000, 16'h0000, "oper ptr read");
    op(ISR_OP_NTR_RD, 16'h0000, 16'h0200, "oper ntr read");
    opcond = '0;
    idle(3);
    chk1("oper summary", 1'b1, oper_summary);
    op(ISR_OP_EVT, 16'h0000, 16'h0200, "oper falling event");
    idle(2);
    chk1("oper summary", 1'b0, oper_summary);
  endtask
  // channel group subregister and its summary into the operation register
  task automatic t_chan;
    int i;
    chan_summary = 4'h1;
    idle(4);
    op(ISR_CH_SEL_WR, 16'h000F, 16'h0000, "chan ena write");
    idle(3);
    op(ISR_OP_COND, 16'h0000, 16'h2000, "group bit set");
    op(ISR_OP_EVT, 16'h0000, 16'h0000, "oper no rising event");
    op(ISR_CH_COND, 16'h0000, 16'h0001, "chan cond");
    op(ISR_CH_EVT, 16'h0000, 16'h0001, "chan event");
    op(ISR_CH_EVT, 16'h0000, 16'h0000, "chan event cleared");
    idle(3);
    op(ISR_OP_COND, 16'h0000, 16'h0000, "group bit clear");
    for (i = 0; i < 3; i++) begin
      op(ISR_CH_SEL_WR, 16'hA5C3, 16'h0000, "chan mask write", isr_sel_t'(i));
      op(ISR_CH_SEL_RD, 16'h0000, 16'hA5C3, "chan mask read", isr_sel_t'(i));
    end
  endtask
  // low clock enable freezes postings; one posted while it is low is dropped and never lands
  task automatic t_ce;
    idle(1);
    ce = 1'b0;
    evq.power_applied = 1'b1;
    idle(1);
    evq = '0;
    idle(1);
    chk16("esr frozen", 16'h0000, {8'h00, esr_view});
    ce = 1'b1;
    op(ISR_ESR_RD, 16'h0000, 16'h0000, "esr after freeze");
  endtask
  // second reset in mid-run restores the chosen mask values
  task automatic t_rst;
    resetn = 1'b0;
    idle(2);
    resetn = 1'b1;
    op(ISR_OP_PTR_RD, 16'h0000, 16'hFFFF, "ptr after reset");
    op(ISR_OP_ENA_RD, 16'h0000, 16'h0000, "ena after reset");
    op(ISR_ESE_RD, 16'h0000, 16'h0000, "ese after reset");
  endtask
  // main sequence
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    evq = '0;
    opcond = '0;
    chan_summary = 4'h0;
    idle(2);
    resetn = 1'b1;
    t_esr();
    t_oper();
    t_chan();
    t_ce();
    t_rst();
    conclude();
  end
endmodule

// ---- logic/isr_pkg.sv ----
// package: status register layout, reset values and host command codes
package isr_pkg;

  // ****************************************************
  // standard event status bit positions
  // ****************************************************
  localparam int ESB_OP_DONE      = 0;
  localparam int ESB_QUERY_FAULT  = 2;
  localparam int ESB_DEV_ERR      = 3;
  localparam int ESB_EXEC_FAULT   = 4;
  localparam int ESB_CMD_FAULT    = 5;
  localparam int ESB_POWER        = 7;
  localparam logic [7:0] ESB_USED_MASK = 8'hBD;

  // ****************************************************
  // operation status bit positions
  // ****************************************************
  localparam int OPB_AWAIT_TRIG   = 5;
  localparam int OPB_CONST_VOLT   = 8;
  localparam int OPB_OUTPUT_ON    = 9;
  localparam int OPB_CONST_CURR   = 10;
  localparam int OPB_OUT_DELAY    = 12;
  localparam int OPB_CHAN_SUMMARY = 13;
  localparam logic [15:0] OPB_USED_MASK = 16'h3720;
  localparam logic [15:0] CHS_USED_MASK = 16'h000F;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [15:0] RST_MASK16    = 16'h0000;
  localparam logic [15:0] RST_PTR16     = 16'hFFFF;
  localparam logic [7:0]  RST_ESE       = 8'h00;
  localparam logic [15:0] RST_EVENT16   = 16'h0000;

  // ****************************************************
  // host command selector
  // ****************************************************
  typedef enum logic [3:0] {
    ISR_NOP       = 4'h0,
    ISR_ESR_RD    = 4'h1,
    ISR_ESE_WR    = 4'h2,
    ISR_ESE_RD    = 4'h3,
    ISR_OP_EVT    = 4'h4,
    ISR_OP_COND   = 4'h5,
    ISR_OP_ENA_WR = 4'h6,
    ISR_OP_ENA_RD = 4'h7,
    ISR_OP_PTR_WR = 4'h8,
    ISR_OP_PTR_RD = 4'h9,
    ISR_OP_NTR_WR = 4'hA,
    ISR_OP_NTR_RD = 4'hB,
    ISR_CH_EVT    = 4'hC,
    ISR_CH_COND   = 4'hD,
    ISR_CH_SEL_WR = 4'hE,
    ISR_CH_SEL_RD = 4'hF
  } isr_cmd_t;

  // which mask of the channel subregister a sel command touches
  typedef enum logic [1:0] {
    ISR_SEL_ENA = 2'h0,
    ISR_SEL_PTR = 2'h1,
    ISR_SEL_NTR = 2'h2
  } isr_sel_t;

  // host request bundle
  typedef struct packed {
    logic        valid;
    isr_cmd_t    cmd;
    isr_sel_t    sel;
    logic [15:0] data;
  } isr_req_t;

  // one-cycle error/event queue postings
  typedef struct packed {
    logic op_done;
    logic query_fault;
    logic device_specific_error;
    logic exec_fault;
    logic cmd_fault;
    logic power_applied;
  } isr_evq_t;

  // live operation conditions
  typedef struct packed {
    logic awaiting_trigger;
    logic const_volt;
    logic output_on;
    logic const_curr;
    logic output_delay_active;
  } isr_opcond_t;

endpackage

// ---- logic/isr_status.sv ----
// module: standard event, operation and channel summary status registers
//
// What this block does
// (RULE1) event status bits come from queue postings
// (RULE2) bit 0 on completed operation sync
// (RULE3) bit 2 on query with nothing queued
// (RULE4) bit 3 on device-specific error
// (RULE5) bit 4 on execution fault
// (RULE6) bit 5 on command fault or trigger
// (RULE7) bit 7 on power applied
// (RULE8) operation register 16 bits, bit15 zero
// (RULE9) operation bit 5 while awaiting trigger
// (RULE10) bits 8,9,10: voltage, output, current
// (RULE11) operation bit 12 during output delay
// (RULE12) operation bit 13 summarises channel subregister
// (RULE13) operation event query clears it
// (RULE14) condition query is live, non-destructive
// (RULE15) operation enable writable and readable
// (RULE16) operation falling mask writable and used
// (RULE17) operation rising mask writable and used
// (RULE18) channels 1-4 map to bits 0-3
// (RULE19) channel event read clears; condition not
// (RULE20) channel masks writable and readable
// (RULE21) events latch from masked condition changes
// (RULE22) rising change needs rising mask
// (RULE23) falling change needs falling mask
// (RULE24) operation summary from event and enable
// (RULE25) unused bits read zero in status, condition and event reads; masks read back as written
// (RULE26) event status read clears; enable summary
`timescale 1ns/100ps
module isr_status #(
  parameter int NCH = 4
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  input  wire isr_pkg::isr_req_t    req,
  input  wire isr_pkg::isr_evq_t    evq,
  input  wire isr_pkg::isr_opcond_t opcond,
  input  wire logic [NCH-1:0]       chan_summary,
  output logic                      rsp_valid,
  output logic [15:0]               rsp_data,
  output logic                      std_event_summary,
  output logic                      oper_summary,
  output logic [7:0]                esr_view
);
  import isr_pkg::*;

  // ****************************************************
  // synchronise channel summaries from other logic
  // ****************************************************
  logic [NCH-1:0] ch_s1_r, ch_s2_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ch_s1_r <= '0;
      ch_s2_r <= '0;
    end else if (ce) begin
      ch_s1_r <= chan_summary;
      ch_s2_r <= ch_s1_r;
    end
  end

  // ****************************************************
  // command decode
  // ****************************************************
  function automatic logic is_cmd(isr_req_t r, isr_cmd_t c);
    return r.valid && (r.cmd == c);
  endfunction

  function automatic logic is_sel_wr(isr_req_t r, isr_sel_t s);
    return r.valid && (r.cmd == ISR_CH_SEL_WR) && (r.sel == s);
  endfunction

  // ****************************************************
  // channel summary subregister
  // ****************************************************
  logic [15:0] ch_cond_in;
  logic [15:0] ch_cond, ch_evt, ch_ena, ch_ptr, ch_ntr;
  logic        ch_sum;

  // (RULE18) channel n summary lands on bit n-1
  always_comb begin
    ch_cond_in = '0;
    ch_cond_in[NCH-1:0] = ch_s2_r;
  end

  // (RULE19) channel event read clears it
  // (RULE20) channel masks from host writes
  isr_xreg #(.W(16)) u_chan (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .cond     (ch_cond_in),
    .used     (CHS_USED_MASK),
    .evt_clr  (is_cmd(req, ISR_CH_EVT)),
    .ena_wr   (is_sel_wr(req, ISR_SEL_ENA)),
    .ptr_wr   (is_sel_wr(req, ISR_SEL_PTR)),
    .ntr_wr   (is_sel_wr(req, ISR_SEL_NTR)),
    .wdata    (req.data),
    .cond_q   (ch_cond),
    .event_q  (ch_evt),
    .enable_q (ch_ena),
    .ptr_q    (ch_ptr),
    .ntr_q    (ch_ntr),
    .summary  (ch_sum)
  );

  // ****************************************************
  // operation status register
  // ****************************************************
  logic [15:0] op_cond_in;
  logic [15:0] op_cond, op_evt, op_ena, op_ptr, op_ntr;
  logic        op_sum;

  always_comb begin
    op_cond_in = '0;
    // (RULE9) awaiting trigger
    op_cond_in[OPB_AWAIT_TRIG]   = opcond.awaiting_trigger;
    // (RULE10) regulation and output state
    op_cond_in[OPB_CONST_VOLT]   = opcond.const_volt;
    op_cond_in[OPB_OUTPUT_ON]    = opcond.output_on;
    op_cond_in[OPB_CONST_CURR]   = opcond.const_curr;
    // (RULE11) output delay sequence
    op_cond_in[OPB_OUT_DELAY]    = opcond.output_delay_active;
    // (RULE12) channel subregister summary
    op_cond_in[OPB_CHAN_SUMMARY] = ch_sum;
  end

  // (RULE13) operation event query clears
  // (RULE15) enable register store
  // (RULE16) falling mask store
  // (RULE17) rising mask store
  isr_xreg #(.W(16)) u_oper (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .cond     (op_cond_in),
    .used     (OPB_USED_MASK),
    .evt_clr  (is_cmd(req, ISR_OP_EVT)),
    .ena_wr   (is_cmd(req, ISR_OP_ENA_WR)),
    .ptr_wr   (is_cmd(req, ISR_OP_PTR_WR)),
    .ntr_wr   (is_cmd(req, ISR_OP_NTR_WR)),
    .wdata    (req.data),
    .cond_q   (op_cond),
    .event_q  (op_evt),
    .enable_q (op_ena),
    .ptr_q    (op_ptr),
    .ntr_q    (op_ntr),
    .summary  (op_sum)
  );

  // ****************************************************
  // standard event status and its enable
  // ****************************************************
  logic [7:0] esr_r, esr_nxt, ese_r, ese_nxt, esr_set;

  always_comb begin
    esr_set = '0;
    // (RULE1) every used bit sourced from the queue
    // (RULE2) operation complete
    esr_set[ESB_OP_DONE]     = evq.op_done;
    // (RULE3) query fault
    esr_set[ESB_QUERY_FAULT] = evq.query_fault;
    // (RULE4) device specific error
    esr_set[ESB_DEV_ERR]     = evq.device_specific_error;
    // (RULE5) execution fault
    esr_set[ESB_EXEC_FAULT]  = evq.exec_fault;
    // (RULE6) command fault or trigger
    esr_set[ESB_CMD_FAULT]   = evq.cmd_fault;
    // (RULE7) power applied
    esr_set[ESB_POWER]       = evq.power_applied;
    // (RULE26) read clears; a posting in the same cycle survives
    esr_nxt = ((is_cmd(req, ISR_ESR_RD) ? '0 : esr_r) | esr_set) & ESB_USED_MASK;
    ese_nxt = is_cmd(req, ISR_ESE_WR) ? req.data[7:0] : ese_r;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      esr_r <= '0;
      ese_r <= RST_ESE;
    end else if (ce) begin
      esr_r <= esr_nxt;
      ese_r <= ese_nxt;
    end
  end

  // ****************************************************
  // read mux and registered outputs
  // ****************************************************
  logic [15:0] rd_nxt, rsp_data_r, ch_sel_rd;
  logic        rsp_valid_r, std_sum_r, op_sum_r;

  always_comb begin
    unique case (req.sel)
      ISR_SEL_PTR: ch_sel_rd = ch_ptr;
      ISR_SEL_NTR: ch_sel_rd = ch_ntr;
      default:     ch_sel_rd = ch_ena;
    endcase
  end

  // reads return the value before any clear of this same cycle
  always_comb begin
    unique case (req.cmd)
      ISR_ESR_RD:    rd_nxt = {8'h00, esr_r};
      ISR_ESE_RD:    rd_nxt = {8'h00, ese_r};
      ISR_OP_EVT:    rd_nxt = op_evt;
      // (RULE14) live condition, no side effect
      ISR_OP_COND:   rd_nxt = op_cond;
      ISR_OP_ENA_RD: rd_nxt = op_ena;
      ISR_OP_PTR_RD: rd_nxt = op_ptr;
      ISR_OP_NTR_RD: rd_nxt = op_ntr;
      ISR_CH_EVT:    rd_nxt = ch_evt;
      ISR_CH_COND:   rd_nxt = ch_cond;
      ISR_CH_SEL_RD: rd_nxt = ch_sel_rd;
      default:       rd_nxt = 16'h0000;
    endcase
    // (RULE8) bit 15 of condition and event reads zero
    // (RULE25) unused bits already masked; masks read back whole
    if (req.cmd inside {ISR_OP_EVT, ISR_OP_COND, ISR_CH_EVT, ISR_CH_COND}) begin
      rd_nxt[15] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= 16'h0000;
      std_sum_r   <= 1'b0;
      op_sum_r    <= 1'b0;
    end else if (ce) begin
      rsp_valid_r <= req.valid;
      rsp_data_r  <= req.valid ? rd_nxt : rsp_data_r;
      // (RULE26) enabled event status summary
      std_sum_r   <= |(esr_nxt & ese_nxt);
      // (RULE24) operation summary to status byte
      op_sum_r    <= op_sum;
    end
  end

  assign rsp_valid         = rsp_valid_r;
  assign rsp_data          = rsp_data_r;
  assign std_event_summary = std_sum_r;
  assign oper_summary      = op_sum_r;
  assign esr_view          = esr_r;
endmodule

// ---- logic/isr_xreg.sv ----
// module: one condition/event/enable/transition register set
`timescale 1ns/100ps
module isr_xreg #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] cond,
  input  wire logic [W-1:0] used,
  input  wire logic         evt_clr,
  input  wire logic         ena_wr,
  input  wire logic         ptr_wr,
  input  wire logic         ntr_wr,
  input  wire logic [W-1:0] wdata,
  output logic [W-1:0]      cond_q,
  output logic [W-1:0]      event_q,
  output logic [W-1:0]      enable_q,
  output logic [W-1:0]      ptr_q,
  output logic [W-1:0]      ntr_q,
  output logic              summary
);
  import isr_pkg::*;

  logic [W-1:0] cond_r, cond_nxt, evt_r, evt_nxt;
  logic [W-1:0] ena_r, ena_nxt, ptr_r, ptr_nxt, ntr_r, ntr_nxt;
  logic [W-1:0] hit;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    cond_nxt = cond & used;
    // (RULE22) rising edge latch
    // (RULE23) falling edge latch
    hit = ((cond_nxt & ~cond_r) & ptr_r) | ((~cond_nxt & cond_r) & ntr_r);
    // (RULE21) read clears, new hit wins
    evt_nxt  = ((evt_clr ? '0 : evt_r) | hit) & used;
    ena_nxt  = ena_wr ? wdata : ena_r;
    ptr_nxt  = ptr_wr ? wdata : ptr_r;
    ntr_nxt  = ntr_wr ? wdata : ntr_r;
  end

  // registers; ptr resets all-ones so rising edges report by default
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cond_r <= W'(RST_EVENT16);
      evt_r  <= W'(RST_EVENT16);
      ena_r  <= W'(RST_MASK16);
      ptr_r  <= W'(RST_PTR16);
      ntr_r  <= W'(RST_MASK16);
    end else if (ce) begin
      cond_r <= cond_nxt;
      evt_r  <= evt_nxt;
      ena_r  <= ena_nxt;
      ptr_r  <= ptr_nxt;
      ntr_r  <= ntr_nxt;
    end
  end

  assign cond_q   = cond_r;
  assign event_q  = evt_r;
  assign enable_q = ena_r;
  assign ptr_q    = ptr_r;
  assign ntr_q    = ntr_r;
  assign summary  = |(evt_r & ena_r);
endmodule
